// [common/zda_pkg.sv]
// Purpose: shared constants for the time-and-date sentence generator
// Assumes: 40 MHz system clock, BCD time and date inputs
// Notes: step numbers index the fixed character layout of one sentence
package zda_pkg;

    localparam int CLK_HZ = 40_000_000;
    // longest completion time after the pulse, in milliseconds
    localparam int DEADLINE_MS = 500;
    // rounded down: a longest time
    localparam int DEADLINE_CYCLES = DEADLINE_MS * (CLK_HZ / 1000);
    localparam int DL_W = 25;
    localparam int STEP_W = 6;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } state_e;

    // header "$GPZDA", index 0 is the dollar sign
    localparam logic [5:0][7:0] HEADER = {8'h41, 8'h44, 8'h5A, 8'h50, 8'h47, 8'h24};
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_POINT = 8'h2E;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [3:0] DIGIT_HI = 4'h3;
    localparam logic [7:0] HEX_NUM_BASE = 8'h30;
    localparam logic [7:0] HEX_ALPHA_BASE = 8'h37;

    // character layout steps
    localparam logic [5:0] S_HDR_LAST = 6'd5;
    localparam logic [5:0] S_COMMA0 = 6'd6;
    localparam logic [5:0] S_TIME = 6'd7;
    localparam logic [5:0] S_POINT = 6'd13;
    localparam logic [5:0] S_COMMA1 = 6'd16;
    localparam logic [5:0] S_DAY = 6'd17;
    localparam logic [5:0] S_COMMA2 = 6'd19;
    localparam logic [5:0] S_MON = 6'd20;
    localparam logic [5:0] S_COMMA3 = 6'd22;
    localparam logic [5:0] S_YEAR = 6'd23;
    localparam logic [5:0] S_COMMA4 = 6'd27;
    localparam logic [5:0] S_SIGN = 6'd28;
    localparam logic [5:0] S_ZHR = 6'd29;
    localparam logic [5:0] S_COMMA5 = 6'd31;
    localparam logic [5:0] S_ZMIN = 6'd32;
    localparam logic [5:0] S_STAR = 6'd34;
    localparam logic [5:0] S_CSUM_HI = 6'd35;
    localparam logic [5:0] S_CSUM_LO = 6'd36;
    localparam logic [5:0] S_CR = 6'd37;
    localparam logic [5:0] S_LF = 6'd38;

endpackage

// [src/char_buffer.sv]
// Purpose: small valid/ready buffer between sentence generator and receiver
// Assumes: single clock, synchronous active-high reset
// Notes: full throughput at one entry; when full it refuses even while draining
`timescale 1ns/1ps
module char_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr;
        logic [PTR_W-1:0] rd;
        logic [CNT_W-1:0] count;
    } buf_s;

    buf_s q;
    buf_s d;
    logic wr_en;
    logic rd_en;

    // honest flags straight from the occupancy count
    assign in_ready = (q.count != CNT_W'(DEPTH));
    assign out_valid = (q.count != '0);
    assign out_data = q.mem[q.rd];
    assign wr_en = in_valid && in_ready;
    assign rd_en = out_valid && out_ready;

    // pointer wrap and occupancy update
    always_comb
    begin
        d = q;
        if (wr_en)
        begin
            d.mem[q.wr] = in_data;
            d.wr = (q.wr == PTR_W'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
        end
        if (rd_en)
        begin
            d.rd = (q.rd == PTR_W'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
        end
        case ({wr_en, rd_en})
            2'b10: d.count = q.count + 1'b1;
            2'b01: d.count = q.count - 1'b1;
            default: d.count = q.count;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

endmodule // char_buffer

// [src/time_date_sentence_gen.sv]
// Purpose: builds one time-and-date serial sentence per second pulse
// Assumes: BCD time/date/zone inputs are valid for the pulse in its own cycle
// Notes: output bytes pass a two-entry buffer; receiver may stall freely
// Summary of operation
// [R01] one sentence per second pulse, done within 500 ms, for that pulse; a pulse while busy and a late sentence are only flagged
// [R02] unsynchronized: sentence still sent, every data field empty between commas
// [R03] field one is UTC time of the pulse as hhmmss.ss
// [R04] fields two to four are day, month and four-digit year
// [R05] field five is zone hour offset, minus sign for east longitude
// [R06] field six is zone minutes offset, two digits
// [R07] header, six fields, asterisk, two-hex XOR checksum, CR and LF framing
`timescale 1ns/1ps
module time_date_sentence_gen #(
    parameter int DEADLINE_CYCLES = zda_pkg::DEADLINE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic second_pulse,
    input wire logic synced,
    input wire logic [31:0] utc_time,
    input wire logic [7:0] date_day,
    input wire logic [7:0] date_month,
    input wire logic [15:0] date_year,
    input wire logic zone_east,
    input wire logic [7:0] zone_hour,
    input wire logic [7:0] zone_min,
    output logic [7:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic busy,
    output logic deadline_miss,
    output logic pulse_overrun
);

    // last elapsed count that still meets the deadline, cut to the counter width
    localparam int DL_LIMIT_I = DEADLINE_CYCLES - 1;
    localparam logic [zda_pkg::DL_W-1:0] DL_LIMIT = DL_LIMIT_I[zda_pkg::DL_W-1:0];

    typedef struct packed {
        zda_pkg::state_e state;
        logic [zda_pkg::STEP_W-1:0] step;
        logic synced;
        logic east;
        logic [31:0] tod;
        logic [7:0] day;
        logic [7:0] month;
        logic [15:0] year;
        logic [7:0] zhr;
        logic [7:0] zmin;
        logic [7:0] csum;
        logic [zda_pkg::DL_W-1:0] elapsed;
        logic late;
        logic miss;
        logic overrun;
    } gen_s;

    gen_s st_q;
    gen_s st_d;
    logic [7:0] ch;
    logic push;
    logic skip;
    logic in_ready;

    // steps that carry data, emptied when not synchronized
    function automatic logic is_data_step(input logic [5:0] s);
        is_data_step = (s >= zda_pkg::S_TIME) && (s < zda_pkg::S_STAR)
            && (s != zda_pkg::S_COMMA1) && (s != zda_pkg::S_COMMA2)
            && (s != zda_pkg::S_COMMA3) && (s != zda_pkg::S_COMMA4)
            && (s != zda_pkg::S_COMMA5);
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] nib);
        hex_char = (nib < 4'hA) ? zda_pkg::HEX_NUM_BASE + {4'h0, nib}
            : zda_pkg::HEX_ALPHA_BASE + {4'h0, nib};
    endfunction

    // pick the BCD digit a data step shows
    function automatic logic [3:0] digit_at(input logic [5:0] s, input gen_s g);
        case (s)
            6'd7: digit_at = g.tod[31:28];
            6'd8: digit_at = g.tod[27:24];
            6'd9: digit_at = g.tod[23:20];
            6'd10: digit_at = g.tod[19:16];
            6'd11: digit_at = g.tod[15:12];
            6'd12: digit_at = g.tod[11:8];
            6'd14: digit_at = g.tod[7:4];
            6'd15: digit_at = g.tod[3:0];
            6'd17: digit_at = g.day[7:4]; // R04
            6'd18: digit_at = g.day[3:0];
            6'd20: digit_at = g.month[7:4];
            6'd21: digit_at = g.month[3:0];
            6'd23: digit_at = g.year[15:12]; // R04
            6'd24: digit_at = g.year[11:8];
            6'd25: digit_at = g.year[7:4];
            6'd26: digit_at = g.year[3:0];
            6'd29: digit_at = g.zhr[7:4];
            6'd30: digit_at = g.zhr[3:0];
            6'd32: digit_at = g.zmin[7:4]; // R06
            6'd33: digit_at = g.zmin[3:0];
            default: digit_at = 4'h0;
        endcase
    endfunction

    // character for the current step
    always_comb
    begin
        ch = 8'h00;
        if (st_q.step <= zda_pkg::S_HDR_LAST)
            ch = zda_pkg::HEADER[st_q.step[2:0]]; // R07
        else
        begin
            case (st_q.step)
                zda_pkg::S_COMMA0, zda_pkg::S_COMMA1, zda_pkg::S_COMMA2,
                zda_pkg::S_COMMA3, zda_pkg::S_COMMA4, zda_pkg::S_COMMA5:
                    ch = zda_pkg::CH_COMMA; // R02
                zda_pkg::S_POINT: ch = zda_pkg::CH_POINT; // R03
                zda_pkg::S_SIGN: ch = zda_pkg::CH_MINUS; // R05
                zda_pkg::S_STAR: ch = zda_pkg::CH_STAR; // R07
                zda_pkg::S_CSUM_HI: ch = hex_char(st_q.csum[7:4]); // R07
                zda_pkg::S_CSUM_LO: ch = hex_char(st_q.csum[3:0]); // R07
                zda_pkg::S_CR: ch = zda_pkg::CH_CR; // R07
                zda_pkg::S_LF: ch = zda_pkg::CH_LF; // R07
                default: ch = {zda_pkg::DIGIT_HI, digit_at(st_q.step, st_q)}; // R03
            endcase
        end
    end

    // skipped steps take one cycle each but emit nothing
    assign skip = (!st_q.synced && is_data_step(st_q.step)) // R02
        || (st_q.step == zda_pkg::S_SIGN && !st_q.east); // R05
    assign push = (st_q.state == zda_pkg::ST_SEND) && !skip;

    // sequencer, field capture and deadline watch
    always_comb
    begin
        st_d = st_q;
        st_d.miss = 1'b0;
        st_d.overrun = 1'b0;
        case (st_q.state)
            zda_pkg::ST_IDLE:
            begin
                if (second_pulse)
                begin
                    // capture at the pulse so the sentence reports that pulse
                    st_d.state = zda_pkg::ST_SEND; // R01
                    st_d.step = '0;
                    st_d.synced = synced;
                    st_d.east = zone_east;
                    st_d.tod = utc_time;
                    st_d.day = date_day;
                    st_d.month = date_month;
                    st_d.year = date_year;
                    st_d.zhr = zone_hour;
                    st_d.zmin = zone_min;
                    st_d.csum = '0;
                    st_d.elapsed = '0;
                    st_d.late = 1'b0;
                end
            end
            zda_pkg::ST_SEND:
            begin
                // a pulse mid-sentence cannot be honoured; flag it
                if (second_pulse)
                    st_d.overrun = 1'b1;
                if (!st_q.late)
                begin
                    if (st_q.elapsed == DL_LIMIT)
                    begin
                        st_d.late = 1'b1; // R01
                        st_d.miss = 1'b1;
                    end
                    else
                        st_d.elapsed = st_q.elapsed + 1'b1;
                end
                if (skip || in_ready)
                begin
                    // checksum covers chars between dollar and asterisk
                    if (push && st_q.step != '0 && st_q.step < zda_pkg::S_STAR)
                        st_d.csum = st_q.csum ^ ch; // R07
                    if (st_q.step == zda_pkg::S_LF)
                        st_d.state = zda_pkg::ST_IDLE;
                    else
                        st_d.step = st_q.step + 1'b1;
                end
            end
            default: st_d.state = zda_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // stall on a full buffer loses no byte
    char_buffer #(
        .WIDTH(8),
        .DEPTH(2)
    ) u_buf (
        .clk(clk),
        .rst(rst),
        .in_data(ch),
        .in_valid(push),
        .in_ready(in_ready),
        .out_data(out_data),
        .out_valid(out_valid),
        .out_ready(out_ready)
    );

    assign busy = (st_q.state == zda_pkg::ST_SEND);
    assign deadline_miss = st_q.miss;
    assign pulse_overrun = st_q.overrun;

    // checks beside the logic
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_start;
        second_pulse && st_q.state == zda_pkg::ST_IDLE;
    endsequence
    sequence s_armed;
        st_q.state == zda_pkg::ST_SEND && st_q.step == '0 && st_q.csum == '0;
    endsequence
    sequence s_cr_taken;
        push && in_ready && st_q.step == zda_pkg::S_CR;
    endsequence

    a_frame_start: assert property (s_start |=> s_armed) // R01
        else $error("pulse did not start a sentence");
    a_deadline_flag: assert property (
        (busy && !st_q.late && st_q.elapsed == DL_LIMIT) |=> deadline_miss ##1 !deadline_miss) // R01
        else $error("deadline miss not flagged once");
    a_null_fields: assert property (
        (push && !st_q.synced && st_q.step > zda_pkg::S_COMMA0 && st_q.step < zda_pkg::S_STAR)
        |-> ch == zda_pkg::CH_COMMA) // R02
        else $error("data emitted while unsynchronized");
    a_time_point: assert property (
        (push && st_q.step == zda_pkg::S_POINT) |-> (ch == zda_pkg::CH_POINT && st_q.synced)) // R03
        else $error("time point wrong");
    a_year_digit: assert property (
        (push && st_q.step == zda_pkg::S_YEAR) |-> ch == {zda_pkg::DIGIT_HI, st_q.year[15:12]}) // R04
        else $error("year digit wrong");
    a_zone_sign: assert property (
        (push && st_q.step == zda_pkg::S_SIGN) |-> (st_q.east && ch == zda_pkg::CH_MINUS)) // R05
        else $error("zone sign wrong");
    a_zone_minutes: assert property (
        (push && st_q.step == zda_pkg::S_ZMIN) |-> ch == {zda_pkg::DIGIT_HI, st_q.zmin[7:4]}) // R06
        else $error("zone minutes digit wrong");
    a_checksum_hi: assert property (
        (push && st_q.step == zda_pkg::S_CSUM_HI) |-> ch == hex_char(st_q.csum[7:4])) // R07
        else $error("checksum digit wrong");
    a_line_end: assert property (
        s_cr_taken ##1 (push && in_ready && ch == zda_pkg::CH_LF) |=> !busy) // R07
        else $error("sentence did not end after line feed");

endmodule // time_date_sentence_gen

// [verif/byte_sink.sv]
// Purpose: receiver model that takes the sentence bytes off the output stream
// Assumes: valid/ready transfer at the rising clock edge
// Notes: slow mode accepts one cycle in four, so the two-entry buffer fills
`timescale 1ns/1ps
module byte_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] out_data,
    input wire logic out_valid,
    input wire logic slow,
    output logic out_ready
);
    logic [1:0] phase_q;
    logic [7:0] got[$];

    // collect accepted bytes; the ready pattern only moves just after an edge
    always @(posedge clk)
    begin
        phase_q <= rst ? 2'h0 : phase_q + 2'h1;
        if (!rst && out_valid && out_ready)
        begin
            got.push_back(out_data);
        end
    end

    // a stalling receiver lowers ready three cycles in four
    assign out_ready = !slow || (phase_q == 2'h0);
endmodule // byte_sink

// [verif/time_date_sentence_gen_test.sv]
// Purpose: self-checking bench for the time-and-date sentence generator
// Assumes: 40 MHz clock, inputs driven at the falling edge
// Notes: deadline shortened to 80 cycles: a stalled full sentence overruns it,
// a stalled empty one stays inside it whatever the receiver's ready phase
`timescale 1ns/1ps
module time_date_sentence_gen_test;
    localparam int DL = 80;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic second_pulse = 1'b0;
    logic synced = 1'b0;
    logic [31:0] utc_time = 32'h0000_0000;
    logic [7:0] date_day = 8'h00;
    logic [7:0] date_month = 8'h00;
    logic [15:0] date_year = 16'h0000;
    logic zone_east = 1'b0;
    logic [7:0] zone_hour = 8'h00;
    logic [7:0] zone_min = 8'h00;
    logic [7:0] out_data;
    logic out_valid;
    logic out_ready;
    logic busy;
    logic deadline_miss;
    logic pulse_overrun;
    logic slow = 1'b0;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    int miss_n = 0;
    int ovr_n = 0;

    time_date_sentence_gen #(.DEADLINE_CYCLES(DL)) dut (.clk(clk), .rst(rst),
        .second_pulse(second_pulse), .synced(synced), .utc_time(utc_time),
        .date_day(date_day), .date_month(date_month), .date_year(date_year),
        .zone_east(zone_east), .zone_hour(zone_hour), .zone_min(zone_min),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
        .busy(busy), .deadline_miss(deadline_miss), .pulse_overrun(pulse_overrun));

    byte_sink sink (.clk(clk), .rst(rst), .out_data(out_data), .out_valid(out_valid),
        .slow(slow), .out_ready(out_ready));

    // clock generator
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // flag pulses counted mid-cycle where settled; a hang is cut short here
    always @(negedge clk)
    begin
        cycles++;
        if (deadline_miss === 1'b1) miss_n++;
        if (pulse_overrun === 1'b1) ovr_n++;
        if (cycles == 20000)
        begin
            fails++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // expected sentence worked out from the field values, checksum included
    function automatic string mk(logic s, logic [31:0] t, logic [7:0] d, logic [7:0] m,
        logic [15:0] y, logic e, logic [7:0] zh, logic [7:0] zm);
        string b;
        string sg;
        string cc;
        logic [7:0] cs;
        cs = 8'h00;
        sg = "";
        if (e)
            sg = "-";
        if (s)
            b = $sformatf("GPZDA,%h.%h,%h,%h,%h,%s%h,%h", t[31:8], t[7:0], d, m, y,
                sg, zh, zm);
        else
            b = "GPZDA,,,,,,";
        foreach (b[i]) cs ^= b[i];
        cc = $sformatf("%h", cs);
        cc = cc.toupper();
        return {"$", b, "*", cc, "\r\n"};
    endfunction

    // one captured pulse plus a dropped mid-sentence pulse when dup, fields scrambled after the capture edge, whole sentence judged
    task automatic run(input logic s, input logic [31:0] t, input logic [7:0] d,
        input logic [7:0] m, input logic [15:0] y, input logic e, input logic [7:0] zh,
        input logic [7:0] zm, input logic stall, input bit dup, input int exp_miss);
        string x;
        int n;
        int m0;
        int o0;
        x = mk(s, t, d, m, y, e, zh, zm);
        m0 = miss_n;
        o0 = ovr_n;
        n = 0;
        sink.got.delete();
        @(negedge clk);
        {synced, utc_time, date_day, date_month, date_year} = {s, t, d, m, y};
        {zone_east, zone_hour, zone_min, slow, second_pulse} = {e, zh, zm, stall, 1'b1};
        @(negedge clk);
        second_pulse = 1'b0;
        {synced, utc_time, date_day, zone_east} = {~s, ~t, ~d, ~e};
        {date_month, date_year, zone_hour, zone_min} = {~m, ~y, ~zh, ~zm};
        while (busy === 1'b1 && n < 1000)
        begin
            n++;
            if (dup && n == 5) second_pulse = 1'b1;
            if (dup && n == 6) second_pulse = 1'b0;
            @(negedge clk);
        end
        if (exp_miss == 0) check(n < DL, 1);
        repeat (12) @(negedge clk);
        check(busy, 1'b0);
        check(out_valid, 1'b0);
        check(miss_n - m0, exp_miss);
        check(ovr_n - o0, dup);
        check(sink.got.size(), x.len());
        foreach (sink.got[i]) check(sink.got[i], (i < x.len()) ? x[i] : 8'h00);
    endtask

    task automatic test_done();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        check(busy, 1'b0);
        // plain west-zone sentence, a pulse dropped while busy
        run(1'b1, 32'h1756_5800, 8'h20, 8'h05, 16'h2008, 1'b0, 8'h07, 8'h00, 1'b0, 1, 0);
        // east zone sign, top of ranges, receiver stalling past the deadline
        run(1'b1, 32'h2359_5999, 8'h31, 8'h12, 16'h2079, 1'b1, 8'h12, 8'h45, 1'b1, 0, 1);
        // unsynchronized sentence with empty fields
        run(1'b0, 32'h1234_5678, 8'h15, 8'h06, 16'h2020, 1'b1, 8'h03, 8'h30, 1'b0, 0, 0);
        // bottom of ranges, half-hour zone, stalled unsynced after it
        run(1'b1, 32'h0000_0000, 8'h01, 8'h01, 16'h1980, 1'b0, 8'h00, 8'h30, 1'b0, 0, 0);
        run(1'b0, 32'h0000_0000, 8'h01, 8'h01, 16'h1980, 1'b0, 8'h00, 8'h00, 1'b1, 1, 0);
        test_done();
    end
endmodule // time_date_sentence_gen_test
